// File: hdl/sport_pkg.sv
package sport_pkg;
  // ----------------------------------------------------------------------
  // transaction layout
  // ----------------------------------------------------------------------
  localparam int FRAME_BITS   = 16;
  localparam int ADDR_BITS    = 6;
  localparam int DATA_BITS    = 8;
  localparam int DIR_POS      = 0;
  localparam int ADDR_POS     = 1;
  localparam int DUMMY_POS    = 7;
  localparam int DATA_POS     = 8;
  localparam logic DIR_WRITE  = 1'b0;
  localparam logic DIR_READ   = 1'b1;
  localparam int REG_COUNT    = 64;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int MCLK_PERIOD_NS  = 25;
  localparam int RESET_MIN_NS    = 30;
  localparam int RESET_MIN_CYC   = (RESET_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS + 1;
  localparam int SCLK_HALF_CYC   = 2;
  localparam int CNT_W           = 5;
endpackage

// File: hdl/sport_if.sv
`timescale 1ns/100ps
interface sport_if;
  logic cs_n;
  logic sclk;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_out_oe_n;
  logic reset_n;
  logic int_n;

  modport device
  (
    input  cs_n,
    input  sclk,
    input  serial_data_in,
    output serial_data_out,
    output serial_data_out_oe_n,
    input  reset_n,
    output int_n
  );

  modport host
  (
    output cs_n,
    output sclk,
    output serial_data_in,
    input  serial_data_out,
    input  serial_data_out_oe_n,
    output reset_n,
    input  int_n
  );
endinterface

// File: hdl/sport_device.sv
// What this block does
// - three host wires, optional readback, interrupt pin int_n tied high and never asserted, reset
// - reset low clears all configuration
// - host sends exactly sixteen bits each
// - sample data on rising serial clock
// - commit nothing before sixteen bits sampled
// - chip select deasserts after every transaction
// - readback changes on falling serial clock
// - every field least significant bit first
// - first bit: zero write, one read
// - bits two to seven carry address
// - eighth bit ignored
// - bits nine to sixteen carry data
// - write lands when chip select rises
// - read data out bits nine to sixteen
`timescale 1ns/100ps
module sport_device
  import sport_pkg::*;
(
  sport_if.device        link,
  input  wire logic      mclk,
  input  wire logic      arst_n,
  input  wire logic [5:0] cfg_addr,
  output logic      [7:0] cfg_data
);
  // ----------------------------------------------------------------------
  // link domain: reset from pin or core
  // ----------------------------------------------------------------------
  logic        rst_n;
  logic [CNT_W-1:0] cnt_q;
  logic [14:0] shift_q;
  logic        done_q;
  logic [7:0]  regs_q [REG_COUNT];
  logic [7:0]  rd_q;
  logic        sdo_q;
  logic        oe_n_q;
  logic        is_read;
  logic [5:0]  addr;

  assign rst_n   = arst_n & link.reset_n;
  assign is_read = shift_q[DIR_POS] == DIR_READ;
  assign addr    = shift_q[ADDR_POS +: ADDR_BITS];

  // ----------------------------------------------------------------------
  // receive shifter, cleared while deselected
  // ----------------------------------------------------------------------
  always_ff @(posedge link.sclk or negedge rst_n or posedge link.cs_n)
  begin
    if (!rst_n || link.cs_n)
    begin
      cnt_q   <= '0;
      shift_q <= '0;
      done_q  <= 1'b0;
    end
    else if (cnt_q < CNT_W'(FRAME_BITS))
    begin
      cnt_q <= cnt_q + 1'b1;
      if (cnt_q == CNT_W'(FRAME_BITS - 1))
        done_q <= 1'b1;
      else
        shift_q[cnt_q[3:0]] <= link.serial_data_in;
    end
  end

  // last data bit is taken from the pin at the sixteenth edge; hold it here
  logic d7_q;
  always_ff @(posedge link.sclk or negedge rst_n)
  begin
    if (!rst_n)
      d7_q <= 1'b0;
    else if (!link.cs_n && cnt_q == CNT_W'(FRAME_BITS - 1))
      d7_q <= link.serial_data_in;
  end

  // ----------------------------------------------------------------------
  // register store, written on chip select release
  // ----------------------------------------------------------------------
  always_ff @(posedge link.cs_n or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < REG_COUNT; i++)
        regs_q[i] <= REG_RESET;
    end
    else if (done_q && !is_read)
      regs_q[addr] <= {d7_q, shift_q[DATA_POS +: DATA_BITS-1]};
  end

  // ----------------------------------------------------------------------
  // readback on falling serial clock
  // ----------------------------------------------------------------------
  always_ff @(negedge link.sclk or negedge rst_n or posedge link.cs_n)
  begin
    if (!rst_n || link.cs_n)
    begin
      rd_q   <= '0;
      sdo_q  <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else if (cnt_q == CNT_W'(DATA_POS) && is_read)
    begin
      rd_q   <= {1'b0, regs_q[addr][7:1]};
      sdo_q  <= regs_q[addr][0];
      oe_n_q <= 1'b0;
    end
    else if (cnt_q > CNT_W'(DATA_POS) && !oe_n_q)
    begin
      sdo_q <= rd_q[0];
      rd_q  <= {1'b0, rd_q[7:1]};
    end
  end

  assign link.serial_data_out      = sdo_q;
  assign link.serial_data_out_oe_n = oe_n_q;
  assign link.int_n                = 1'b1;

  // ----------------------------------------------------------------------
  // core view of one register, words cross via three-stage sampling, taken when the last two stages agree
  // ----------------------------------------------------------------------
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic [7:0] s3_q;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_q     <= '0;
      s2_q     <= '0;
      s3_q     <= '0;
      cfg_data <= '0;
    end
    else
    begin
      s1_q <= regs_q[cfg_addr];
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        cfg_data <= s3_q;
    end
  end
endmodule

// File: hdl/sport_host.sv
`timescale 1ns/100ps
module sport_host
  import sport_pkg::*;
(
  sport_if.host              link,
  input  wire logic          mclk,
  input  wire logic          arst_n,
  input  wire logic          req_valid,
  output logic               req_ready,
  input  wire logic          req_read,
  input  wire logic [5:0]    req_addr,
  input  wire logic [7:0]    req_wdata,
  output logic               rsp_valid,
  output logic [7:0]         rsp_rdata
);
  typedef enum logic [1:0] {IDLE, SHIFT, GAP} state_t;
  state_t         state_q;
  logic [15:0]    frame_q;
  logic [CNT_W-1:0] bit_q;
  logic [1:0]     div_q;
  logic           read_q;
  logic [7:0]     rx_q;
  logic           sdo_m_q;
  logic           sdo_s_q;
  logic           sclk_q;
  logic           cs_n_q;
  logic           sdi_q;

  assign req_ready       = state_q == IDLE;
  assign link.sclk       = sclk_q;
  assign link.cs_n       = cs_n_q;
  assign link.serial_data_in = sdi_q;
  assign link.reset_n    = arst_n;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sdo_m_q <= 1'b0;
      sdo_s_q <= 1'b0;
    end
    else
    begin
      sdo_m_q <= link.serial_data_out;
      sdo_s_q <= sdo_m_q;
    end
  end

  // ----------------------------------------------------------------------
  // frame sequencer, clock divided from mclk
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q   <= IDLE;
      frame_q   <= '0;
      bit_q     <= '0;
      div_q     <= '0;
      read_q    <= 1'b0;
      rx_q      <= '0;
      sclk_q    <= 1'b0;
      cs_n_q    <= 1'b1;
      sdi_q     <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      case (state_q)
        IDLE:
        begin
          if (req_valid)
          begin
            frame_q <= {req_wdata, 1'b0, req_addr, req_read};
            read_q  <= req_read;
            bit_q   <= '0;
            div_q   <= '0;
            cs_n_q  <= 1'b0;
            sdi_q   <= req_read;
            state_q <= SHIFT;
          end
        end
        SHIFT:
        begin
          div_q <= div_q + 1'b1;
          if (div_q == 2'(SCLK_HALF_CYC - 1))
            sclk_q <= 1'b1;
          else if (div_q == 2'(2 * SCLK_HALF_CYC - 1))
          begin
            sclk_q <= 1'b0;
            // the synchronised pin shows the bit launched one serial clock earlier, so sampling starts at data bit zero
            if (bit_q >= CNT_W'(DATA_POS) && read_q)
              rx_q <= {sdo_s_q, rx_q[7:1]};
            bit_q <= bit_q + 1'b1;
            if (bit_q == CNT_W'(FRAME_BITS - 1))
            begin
              state_q <= GAP;
            end
            else
              sdi_q <= frame_q[bit_q[3:0] + 4'd1];
          end
        end
        GAP:
        begin
          div_q <= div_q + 1'b1;
          if (div_q == 2'(2 * SCLK_HALF_CYC - 1))
          begin
            if (!cs_n_q)
              cs_n_q <= 1'b1;
            else
            begin
              rsp_valid <= 1'b1;
              rsp_rdata <= read_q ? rx_q : '0;
              state_q   <= IDLE;
            end
          end
        end
        default:
          state_q <= IDLE;
      endcase
    end
  end
endmodule

// File: verification/sport_properties.sv
`timescale 1ns/100ps
module sport_properties
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe_n
);
  logic [4:0] rises_q;
  logic       sclk_q;
  // ----------------------------------------------------------------------
  // serial clock rises counted within a frame
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      rises_q <= 5'h00;
      sclk_q  <= 1'b0;
    end
    else
    begin
      sclk_q  <= sclk;
      rises_q <= cs_n ? 5'h00 : rises_q + 5'(sclk && !sclk_q);
    end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence sclk_pulse;
    sclk ##1 !sclk;
  endsequence
  sequence frame_start;
    ##[0:4] $rose(sclk);
  endsequence
  a_sclk_idle_low: assert property (cs_n |-> !sclk) else $error("serial clock high outside frame");
  a_sclk_shape: assert property ($rose(sclk) |-> ##1 sclk_pulse) else $error("serial clock shape");
  a_frame_start: assert property ($fell(cs_n) |-> frame_start) else $error("frame start late");
  a_sixteen_bits: assert property ($rose(cs_n) |-> rises_q == 5'h10) else $error("frame not 16 bits");
  a_cs_gap: assert property ($rose(cs_n) |-> cs_n[*4]) else $error("chip select gap short");
  a_sdi_steady: assert property (!cs_n && $changed(serial_data_in) |-> !sclk) else $error("data moved high");
  a_oe_release: assert property (cs_n && $past(cs_n) |-> serial_data_out_oe_n) else $error("output not released");
  a_oe_start: assert property ($fell(serial_data_out_oe_n) |-> rises_q == 5'h08 && $fell(sclk))
    else $error("readback started at wrong bit");
  a_sdo_fall_only: assert property (!serial_data_out_oe_n && !$past(serial_data_out_oe_n)
    && $changed(serial_data_out) |-> $fell(sclk)) else $error("readback moved off falling edge");
endmodule

// File: verification/tb_serial_host_register_port.sv
`timescale 1ns/100ps
module tb_serial_host_register_port;
  import sport_pkg::*;
  logic       mclk = 1'b0;
  logic       arst_n = 1'b0;
  logic       req_valid = 1'b0;
  logic       req_read = 1'b0;
  logic       req_ready;
  logic       rsp_valid;
  logic [5:0] req_addr = 6'h00;
  logic [5:0] cfg_addr = 6'h00;
  logic [5:0] cfg_addr_b = 6'h00;
  logic [7:0] req_wdata = 8'h00;
  logic [7:0] rsp_rdata;
  logic [7:0] cfg_data;
  logic [7:0] cfg_data_b;
  logic [7:0] rd;
  int         mismatches = 0;
  int         checks = 0;
  sport_if link_if();
  sport_if raw_if();
  always #12.5 mclk = ~mclk;
  sport_host sport_host_i (.link(link_if.host), .mclk(mclk), .arst_n(arst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_read(req_read), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  sport_device sport_device_i (.link(link_if.device), .mclk(mclk), .arst_n(arst_n),
    .cfg_addr(cfg_addr), .cfg_data(cfg_data));
  sport_device sport_device_b_i (.link(raw_if.device), .mclk(mclk), .arst_n(arst_n),
    .cfg_addr(cfg_addr_b), .cfg_data(cfg_data_b));
  sport_properties sport_properties_i (.mclk(mclk), .arst_n(arst_n), .cs_n(link_if.cs_n), .sclk(link_if.sclk),
    .serial_data_in(link_if.serial_data_in), .serial_data_out(link_if.serial_data_out),
    .serial_data_out_oe_n(link_if.serial_data_out_oe_n));
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic txn(input logic r, input logic [5:0] a, input logic [7:0] d);
    int n;
    @(negedge mclk);
    req_valid = 1'b1;
    req_read  = r;
    req_addr  = a;
    req_wdata = d;
    for (n = 0; req_ready !== 1'b1 && n < 200; n++) @(negedge mclk);
    @(negedge mclk);
    req_valid = 1'b0;
    for (n = 0; rsp_valid !== 1'b1 && n < 200; n++) @(negedge mclk);
    chk(8'(n < 200), 8'h01);
    rd = rsp_rdata;
  endtask
  task automatic peek(input logic b, input logic [5:0] a, input logic [7:0] e);
    cfg_addr   = a;
    cfg_addr_b = a;
    repeat (12) @(negedge mclk);
    chk(b ? cfg_data_b : cfg_data, e);
  endtask
  // frame driven by hand, chip select left low at the end
  task automatic raw(input logic [15:0] f, input int n);
    @(negedge mclk);
    raw_if.cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      raw_if.serial_data_in = f[i];
      #24 raw_if.sclk = 1'b1;
      #24 raw_if.sclk = 1'b0;
    end
  endtask
  task automatic end_raw;
    #24 raw_if.cs_n = 1'b1;
    raw_if.serial_data_in = ~raw_if.serial_data_in;
    #48;
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_defaults;
    txn(1'b1, 6'h00, 8'h00);
    chk(rd, REG_RESET);
    txn(1'b1, 6'h3F, 8'h00);
    chk(rd, REG_RESET);
  endtask
  task automatic t_rw;
    txn(1'b0, 6'h00, 8'hA5);
    txn(1'b0, 6'h3F, 8'h5A);
    txn(1'b0, 6'h01, 8'h01);
    peek(1'b0, 6'h00, 8'hA5);
    peek(1'b0, 6'h3F, 8'h5A);
    txn(1'b1, 6'h3F, 8'hFF);
    chk(rd, 8'h5A);
    txn(1'b1, 6'h00, 8'h00);
    chk(rd, 8'hA5);
    txn(1'b1, 6'h01, 8'h00);
    chk(rd, 8'h01);
    txn(1'b1, 6'h20, 8'h00);
    chk(rd, 8'h00);
    peek(1'b0, 6'h3F, 8'h5A);
  endtask
  task automatic t_raw;
    raw(16'h3C8A, 16);
    peek(1'b1, 6'h05, 8'h00);
    end_raw;
    peek(1'b1, 6'h05, 8'h3C);
    raw(16'hFF0A, 12);
    end_raw;
    peek(1'b1, 6'h05, 8'h3C);
    raw_if.reset_n = 1'b0;
    #40 raw_if.reset_n = 1'b1;
    peek(1'b1, 6'h05, 8'h00);
  endtask
  initial
  begin
    raw_if.cs_n           = 1'b1;
    raw_if.sclk           = 1'b0;
    raw_if.serial_data_in = 1'b0;
    raw_if.reset_n        = 1'b1;
    repeat (6) @(negedge mclk);
    arst_n = 1'b1;
    t_defaults;
    t_rw;
    t_raw;
    print_verdict;
  end
  initial
  begin
    #400000;
    mismatches++;
    print_verdict;
  end
endmodule
